// File: src/valve_cmd_regs.vh
// Purpose: Constants for the valve position command logic
// Assumes: 125 MHz system clock
// Notes: Times kept in their own unit, cycle counts derived from them
`ifndef VALVE_CMD_REGS_VH
`define VALVE_CMD_REGS_VH
`define CLK_MHZ 125
`define CLOSURE_MS 20
`define CLOSURE_CYC (`CLOSURE_MS * 1000 * `CLK_MHZ)
`define SETUP_HOLD_S 5
`define SETUP_HOLD_CYC (`SETUP_HOLD_S * 1000 * 1000 * `CLK_MHZ)
`define BTN_DEB_CYC 24'd2
`define POS_W 6
`define POS_A 6'h00
`define POS_B 6'h01
`define POS_HOME 6'h01
`define POS_STEP 6'h01
`define MODE_NORMAL 3'h1
`define MODE_SETUP 3'h2
`define MODE_FACTORY 3'h4
`endif

// File: src/valve_position_command_logic.v
// Purpose: Turns remote buttons and contact closures into valve position targets
// Assumes: Inputs synchronous to clk_sys; motor logic reports arrival and position
// Notes: Contact inputs are active low (closure to common pulls them low)
// Operation
// - In two-position use an up press targets B, and does nothing when already at B.
// - In multiposition use each up press advances the target by one index.
// - In two-position use a down press targets A, and does nothing when already at A.
// - In multiposition use each down press steps the target back by one index.
// - In two-position use a home press targets A, and does nothing when already at A.
// - In multiposition use a home press targets index one.
// - Holding home for five seconds puts the panel in setup mode.
// - An up press in setup mode returns the panel to normal positioning.
// - Holding both arrows opens factory mode, left by an up press with no change applied.
// - In two-position use a position-A closure held at least 20 ms commands a move to A.
// - Releasing a closure starts no motion.
// - In two-position use a position-B closure held at least 20 ms commands a move to B.
// - In two-position use each feedback output goes high once the valve has reached its position.
`timescale 1ns/10ps
`include "valve_cmd_regs.vh"

module valve_position_command_logic #(
	parameter [31:0] CLOSURE_CYCLES = `CLOSURE_CYC,
	parameter [31:0] SETUP_HOLD_CYCLES = `SETUP_HOLD_CYC
)(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Configuration
	input wire multipos_cfg,
	// Remote panel buttons, high while pressed
	input wire btn_up,
	input wire btn_down,
	input wire btn_home,
	// Contact inputs, low while closed to common
	input wire contact_a_n,
	input wire contact_b_n,
	// Motor positioning side
	input wire [`POS_W-1:0] cur_pos,
	input wire arrived,
	output reg [`POS_W-1:0] target_pos,
	output reg move_req,
	// Panel mode and feedback
	output wire setup_mode,
	output wire factory_mode,
	output reg fb_a,
	output reg fb_b
);

	// ------------------------------------------------------------
	// Contact filtering
	// ------------------------------------------------------------
	reg [31:0] cnt_a_q;
	reg [31:0] cnt_b_q;
	reg a_stable_q;
	reg b_stable_q;
	reg a_sync1_q, a_sync2_q, b_sync1_q, b_sync2_q;

	// Two-flop sync even though inputs are nominally synchronous: contacts bounce
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			a_sync1_q <= 1'b0;
			a_sync2_q <= 1'b0;
			b_sync1_q <= 1'b0;
			b_sync2_q <= 1'b0;
		end
		else
		begin
			a_sync1_q <= ~contact_a_n;
			a_sync2_q <= a_sync1_q;
			b_sync1_q <= ~contact_b_n;
			b_sync2_q <= b_sync1_q;
		end
	end

	// Level accepted only after holding for the full closure time
	// Any bounce restarts the count, so chatter delays a move rather than faking one
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_a_q <= 32'h00000000;
			cnt_b_q <= 32'h00000000;
			a_stable_q <= 1'b0;
			b_stable_q <= 1'b0;
		end
		else
		begin
			if (a_sync2_q == a_stable_q)
				cnt_a_q <= 32'h00000000;
			else if (cnt_a_q >= CLOSURE_CYCLES - 32'h00000001)
			begin
				a_stable_q <= a_sync2_q;
				cnt_a_q <= 32'h00000000;
			end
			else
				cnt_a_q <= cnt_a_q + 32'h00000001;
			if (b_sync2_q == b_stable_q)
				cnt_b_q <= 32'h00000000;
			else if (cnt_b_q >= CLOSURE_CYCLES - 32'h00000001)
			begin
				b_stable_q <= b_sync2_q;
				cnt_b_q <= 32'h00000000;
			end
			else
				cnt_b_q <= cnt_b_q + 32'h00000001;
		end
	end

	// Edge detect on the filtered levels; only closure counts
	reg a_prev_q, b_prev_q;
	wire a_close = a_stable_q & ~a_prev_q;
	wire b_close = b_stable_q & ~b_prev_q;

	// ------------------------------------------------------------
	// Button edges and hold timing
	// ------------------------------------------------------------
	reg up_q, down_q, home_q;
	reg [31:0] hold_q;
	reg both_q;
	wire up_press = btn_up & ~up_q;
	wire down_press = btn_down & ~down_q;
	wire home_press = btn_home & ~home_q;

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			up_q <= 1'b0;
			down_q <= 1'b0;
			home_q <= 1'b0;
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
			both_q <= 1'b0;
		end
		else
		begin
			up_q <= btn_up;
			down_q <= btn_down;
			home_q <= btn_home;
			a_prev_q <= a_stable_q;
			b_prev_q <= b_stable_q;
			both_q <= btn_up & btn_down;
		end
	end

	// Home hold counter, saturates so a long hold fires once
	// Limitation: a hold that outlasts setup entry does not re-enter after an exit
	wire hold_done = (hold_q == SETUP_HOLD_CYCLES - 32'h00000001);
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			hold_q <= 32'h00000000;
		else if (!btn_home)
			hold_q <= 32'h00000000;
		else if (hold_q < SETUP_HOLD_CYCLES)
			hold_q <= hold_q + 32'h00000001;
	end

	// ------------------------------------------------------------
	// Panel mode machine
	// ------------------------------------------------------------
	localparam [2:0] ST_NORMAL = `MODE_NORMAL;
	localparam [2:0] ST_SETUP = `MODE_SETUP;
	localparam [2:0] ST_FACTORY = `MODE_FACTORY;
	reg [2:0] mode_q, mode_d;

	always @*
	begin
		mode_d = mode_q;
		case (mode_q)
			ST_NORMAL:
				if (btn_up & btn_down & ~both_q)
					mode_d = ST_FACTORY;
				else if (hold_done)
					mode_d = ST_SETUP;
			ST_SETUP:
				if (up_press & ~btn_down)
					mode_d = ST_NORMAL;
			ST_FACTORY:
				// Wait for both arrows released before accepting the exit press
				if (up_press & ~btn_down)
					mode_d = ST_NORMAL;
			default:
				mode_d = ST_NORMAL;
		endcase
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			mode_q <= ST_NORMAL;
		else
			mode_q <= mode_d;
	end

	assign setup_mode = mode_q[1];
	assign factory_mode = mode_q[2];

	// ------------------------------------------------------------
	// Target generation
	// ------------------------------------------------------------
	// Buttons act only in normal mode; arrow pairs are factory entry, not moves
	// Priority is contact A, contact B, up, down, home; the multiposition index wraps
	wire normal = (mode_q == ST_NORMAL) & ~(btn_up & btn_down);
	reg [`POS_W-1:0] tgt_d;
	reg req_d;

	always @*
	begin
		tgt_d = target_pos;
		req_d = 1'b0;
		if (!multipos_cfg && a_close)
		begin
			tgt_d = `POS_A;
			req_d = (cur_pos != `POS_A);
		end
		else if (!multipos_cfg && b_close)
		begin
			tgt_d = `POS_B;
			req_d = (cur_pos != `POS_B);
		end
		else if (normal && up_press)
		begin
			if (multipos_cfg)
			begin
				tgt_d = target_pos + `POS_STEP;
				req_d = 1'b1;
			end
			else
			begin
				tgt_d = `POS_B;
				req_d = (cur_pos != `POS_B);
			end
		end
		else if (normal && down_press)
		begin
			if (multipos_cfg)
			begin
				tgt_d = target_pos - `POS_STEP;
				req_d = 1'b1;
			end
			else
			begin
				tgt_d = `POS_A;
				req_d = (cur_pos != `POS_A);
			end
		end
		else if (normal && home_press)
		begin
			if (multipos_cfg)
			begin
				tgt_d = `POS_HOME;
				req_d = 1'b1;
			end
			else
			begin
				tgt_d = `POS_A;
				req_d = (cur_pos != `POS_A);
			end
		end
	end

	// Target and request registered; request is a one-cycle pulse
	// A press at the held position still rewrites target_pos; only the request is held back
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			target_pos <= `POS_A;
			move_req <= 1'b0;
		end
		else
		begin
			target_pos <= tgt_d;
			move_req <= req_d;
		end
	end

	// ------------------------------------------------------------
	// Position feedback
	// ------------------------------------------------------------
	// Meaningful in two-position use only; both low while moving
	// Registered so the pins cannot glitch while cur_pos and arrived settle
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			fb_a <= 1'b0;
			fb_b <= 1'b0;
		end
		else
		begin
			fb_a <= ~multipos_cfg & arrived & (cur_pos == `POS_A);
			fb_b <= ~multipos_cfg & arrived & (cur_pos == `POS_B);
		end
	end

endmodule // valve_position_command_logic

// File: sim/valve_cmd_checker_assertions.sv
// Purpose: Port checker for the valve command logic
// Assumes: Single clock, rst asynchronous active high
// Notes: Contact window is sized from CLOSURE_CYCLES
`timescale 1ns/10ps
module valve_cmd_checker #(
	parameter [31:0] CLOSURE_CYCLES = 32'd8
)(
	input wire clk_sys, input wire rst, input wire multipos_cfg,
	input wire btn_up, input wire btn_down, input wire btn_home,
	input wire contact_a_n, input wire contact_b_n,
	input wire [5:0] cur_pos, input wire arrived,
	input wire [5:0] target_pos, input wire move_req,
	input wire setup_mode, input wire factory_mode, input wire fb_a, input wire fb_b
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Run length of a closure; margin of 3 covers the input synchroniser
	logic [31:0] lo_q;
	always @(posedge clk_sys or posedge rst)
		if (rst)
			lo_q <= 32'h0;
		else
			lo_q <= contact_a_n ? 32'h0 : lo_q + 32'h1;
	// Panel idle apart from the press in question
	sequence s_norm;
		!setup_mode && !factory_mode && contact_a_n && contact_b_n;
	endsequence
	sequence s_up;
		$rose(btn_up) && !btn_down ##0 s_norm;
	endsequence
	a_fb_a_pos: assert property (fb_a |-> $past(!multipos_cfg && cur_pos == 6'h00 && arrived))
		else $error("fb_a high away from A");
	a_fb_b_pos: assert property (fb_b |-> $past(!multipos_cfg && cur_pos == 6'h01 && arrived))
		else $error("fb_b high away from B");
	a_up_two: assert property (s_up ##0 !multipos_cfg |=> target_pos == 6'h01)
		else $error("up press did not target B");
	a_up_multi: assert property (s_up ##0 multipos_cfg |=> target_pos == $past(target_pos) + 6'h01)
		else $error("up press did not advance one index");
	a_down_multi: assert property ($rose(btn_down) && !btn_up && multipos_cfg ##0 s_norm
		|=> target_pos == $past(target_pos) - 6'h01)
		else $error("down press did not step back one index");
	a_home_target: assert property ($rose(btn_home) && !btn_up && !btn_down ##0 s_norm
		|=> target_pos == (multipos_cfg ? 6'h01 : 6'h00))
		else $error("home press gave wrong target");
	a_setup_exit: assert property (setup_mode && $rose(btn_up) && !btn_down |=> !setup_mode && !move_req)
		else $error("up press did not leave setup");
	a_factory_exit: assert property (factory_mode && $rose(btn_up) && !btn_down |=> !factory_mode)
		else $error("up press did not leave factory mode");
	a_closure_a: assert property (!multipos_cfg && cur_pos != 6'h00 && lo_q == CLOSURE_CYCLES + 32'd3
		|-> ##[0:3] (move_req && target_pos == 6'h00))
		else $error("held A closure gave no move to A");
endmodule // valve_cmd_checker
bind valve_position_command_logic valve_cmd_checker #(.CLOSURE_CYCLES(CLOSURE_CYCLES)) chk (.*);

// File: sim/valve_motor_model.sv
// Purpose: Motor positioning side, moves to target after a delay
// Assumes: move_req is a one-cycle pulse
// Notes: DLY sets prompt or slow travel
`timescale 1ns/10ps
module valve_motor_model #(
	parameter int DLY = 3
)(
	input wire clk_sys,
	input wire rst,
	input wire move_req,
	input wire [5:0] target_pos,
	output logic [5:0] cur_pos,
	output logic arrived
);
	int cnt;
	// Arrival only after travel; a new request restarts it
	always @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			cur_pos <= 6'h00;
			arrived <= 1'b1;
			cnt <= 0;
		end
		else if (move_req)
		begin
			arrived <= 1'b0;
			cnt <= DLY;
		end
		else if (cnt == 1)
		begin
			cur_pos <= target_pos;
			arrived <= 1'b1;
			cnt <= 0;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
endmodule // valve_motor_model

// File: sim/valve_position_command_logic_test.sv
// Purpose: Scenario bench for the valve command logic
// Assumes: Short counts of 8 and 20 cycles
// Notes: Moves are counted over a whole press and release
`timescale 1ns/10ps
module valve_position_command_logic_test;
	logic clk_sys = 1'b0, rst = 1'b1, multipos_cfg = 1'b0;
	logic btn_up = 1'b0, btn_down = 1'b0, btn_home = 1'b0;
	logic contact_a_n = 1'b1, contact_b_n = 1'b1;
	logic [5:0] cur_pos, target_pos;
	logic arrived, move_req, setup_mode, factory_mode, fb_a, fb_b;
	int failures = 0, tests_run = 0;
	localparam logic [4:0] UP = 5'h10, DN = 5'h08, HM = 5'h04, CA = 5'h02, CB = 5'h01;
	always #4 clk_sys = ~clk_sys;
	valve_position_command_logic #(.CLOSURE_CYCLES(32'd8), .SETUP_HOLD_CYCLES(32'd20)) DUT (.*);
	valve_motor_model motor (.clk_sys(clk_sys), .rst(rst), .move_req(move_req), .target_pos(target_pos),
		.cur_pos(cur_pos), .arrived(arrived));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Hold inputs n cycles, release, count move pulses; one input at a time keeps closures apart
	task act(input logic [4:0] m, input int n, input int exp);
		logic [31:0] mv;
		mv = 32'h0;
		{btn_up, btn_down, btn_home} = m[4:2];
		contact_a_n = !m[1];
		contact_b_n = !m[0];
		repeat (n + 16)
		begin
			@(posedge clk_sys);
			#1;
			mv += move_req;
			if (--n == 0)
			begin
				{btn_up, btn_down, btn_home} = 3'h0;
				{contact_a_n, contact_b_n} = 2'h3;
			end
		end
		check(mv, exp);
	endtask
	task report_and_stop;
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task two_pos_buttons;
		act(UP, 2, 1);
		check(fb_b, 1);
		act(UP, 2, 0);
		act(DN, 2, 1);
		check(fb_a, 1);
		act(HM, 2, 0);
	endtask
	task contacts;
		act(CB, 14, 1);
		check(target_pos, 1);
		act(CA, 4, 0);
		act(CA, 14, 1);
		check(target_pos, 0);
	endtask
	task multi_buttons;
		multipos_cfg = 1'b1;
		act(HM, 2, 1);
		check(target_pos, 1);
		act(UP, 2, 1);
		check(target_pos, 2);
		act(DN, 2, 1);
		check(target_pos, 1);
		act(CA, 14, 0);
		check(target_pos, 1);
		multipos_cfg = 1'b0;
		act(DN, 2, 1);
	endtask
	task modes;
		act(HM, 30, 0);
		check(setup_mode, 1);
		act(UP, 2, 0);
		check(setup_mode, 0);
		act(UP | DN, 4, 0);
		check(factory_mode, 1);
		act(UP, 2, 0);
		check(factory_mode, 0);
	endtask
	// Reset for three cycles, then the scenarios in turn
	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1 rst = 1'b0;
		two_pos_buttons;
		contacts;
		multi_buttons;
		modes;
		report_and_stop;
	end
endmodule // valve_position_command_logic_test
